// File: hw/romc_pkg.sv
/*
 Package of the radio operating mode controller: modes, start-up phases,
 power mode register codes and timing counts.
 Assumes a single 40 MHz clock.
*/
package romc_pkg;
	localparam int CLOCK_HZ = 40000000;
	localparam int LP_CLOCK_HZ = 400000;
	localparam int LP_DIV = CLOCK_HZ / LP_CLOCK_HZ;
	localparam logic [7:0] PWR_STANDBY = 8'h00;
	localparam logic [5:0] PWR_BATT_PROT = 6'h3f;
	localparam int PWR_DEEP_IDLE_BIT = 6;
	localparam int PWR_LP_STANDBY_BIT = 7;
	localparam logic [5:0] CAL_CHANNEL = 6'h13;
	// Settling times in microseconds
	localparam int T_STDBY_RF_US = 100;
	localparam int T_RX_TX_US = 100;
	localparam int T_AUTOCAL_US = 500;
	localparam int T_LPSTDBY_EXIT_US = 1000;
	localparam int T_DEEP_EXIT_US = 2500;
	localparam int T_STDBY_RF_CYC = T_STDBY_RF_US * (CLOCK_HZ / 1000000);
	localparam int T_RX_TX_CYC = T_RX_TX_US * (CLOCK_HZ / 1000000);
	localparam int T_AUTOCAL_CYC = T_AUTOCAL_US * (CLOCK_HZ / 1000000);
	localparam int T_LPSTDBY_EXIT_CYC = T_LPSTDBY_EXIT_US * (CLOCK_HZ / 1000000);
	localparam int T_DEEP_EXIT_CYC = T_DEEP_EXIT_US * (CLOCK_HZ / 1000000);
	localparam int TIMER_W = 20;
	localparam logic [3:0] RETRY_MAX_RESET = 4'h3;

	typedef enum logic [3:0] {
		ROMC_BOOT_RC = 4'b0000,
		ROMC_BOOT_XTAL = 4'b0001,
		ROMC_STANDBY = 4'b0010,
		ROMC_TX = 4'b0011,
		ROMC_TX_ACK_WAIT = 4'b0100,
		ROMC_RX = 4'b0101,
		ROMC_RX_ACK_TX = 4'b0110,
		ROMC_CAL = 4'b0111,
		ROMC_DEEP_IDLE = 4'b1000,
		ROMC_LP_STANDBY = 4'b1001,
		ROMC_EXIT_WAIT = 4'b1010,
		ROMC_BATT_PROT = 4'b1011,
		ROMC_SETTLE = 4'b1100
	} romc_mode_t;

	typedef enum logic [2:0] {
		ROMC_CMD_NONE = 3'b000,
		ROMC_CMD_TX = 3'b001,
		ROMC_CMD_RX = 3'b010,
		ROMC_CMD_CAL = 3'b011,
		ROMC_CMD_POWER = 3'b100
	} romc_cmd_t;
endpackage

// File: hw/romc_timer_if.sv
/*
 Interface between the mode controller and its settling timer.
 Assumes one clock shared by both modules.
*/
`timescale 1ns/100ps
interface romc_timer_if;
	logic load;
	logic [romc_pkg::TIMER_W-1:0] count;
	logic done;
	modport ctrl (output load, output count, input done);
	modport timer (input load, input count, output done);
endinterface

// File: hw/romc_timer.sv
/*
 Settling timer and 400 kHz enable divider.
 Assumes synchronous active-low reset and a 40 MHz clock.
*/
`timescale 1ns/100ps
module romc_timer
(
	input wire logic i_clock, // System clock
	input wire logic i_reset_n, // Synchronous reset
	input wire logic i_slow, // Count on slow enable only
	output logic o_slow_en, // 400 kHz enable pulse
	romc_timer_if.timer t // Load and done
);
	typedef struct packed {
		logic [romc_pkg::TIMER_W-1:0] left;
		logic done;
		logic [7:0] div;
		logic slow_en;
	} romc_timer_state_t;
	romc_timer_state_t state, next_state;

	always_comb
	begin
		next_state = state;
		next_state.slow_en = 1'b0;
		if (state.div == 8'(romc_pkg::LP_DIV - 1))
		begin
			next_state.div = 8'h00;
			next_state.slow_en = 1'b1;
		end
		else
			next_state.div = state.div + 8'h01;
		next_state.done = 1'b0;
		if (t.load)
			next_state.left = t.count;
		else if (state.left != '0 && (!i_slow || state.slow_en))
		begin
			next_state.left = state.left - 1'b1;
			next_state.done = (state.left == 1);
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign t.done = state.done;
	assign o_slow_en = state.slow_en;
endmodule // romc_timer

// File: hw/romc_ctrl.sv
/*
 Operating mode controller: start-up sequencing, standby hub, radio modes,
 auto-acknowledge turnaround, retransmission and power saving modes.
 Assumes the host command port is decoded from the serial interface into
 one-cycle strobes, and radio events arrive as one-cycle pulses.
*/
// Operation
// R1: Radio disabled until start-up finishes
// R2: Supply ok powers crystal, amplitude enables regulation
// R3: Start-up done raises interrupt pin
// R4: No-converter: RC, crystal, interrupt, stop RC
// R5: Reset lands in standby after start-up
// R6: Mode changes accepted only in standby
// R7: One-shot transmit returns to standby
// R8: Battery protection: all off until repower
// R9: Battery protection accepted from any mode; the code ignores it until start-up finishes
// R10: Host checks supply after start-up
// R11: Deep idle from standby, lowered core supply
// R12: Low-power standby: weak crystal, 400kHz clock
// R13: Low-power standby from standby, faster exit
// R14: Plain transmit: one packet, standby, interrupt
// R15: Auto-ack transmit waits ack in receive
// R16: Missing or bad ack triggers retransmission
// R17: Back-to-back packets; transmit only from standby
// R18: Receive interrupts; auto-ack answers, stays receive
// R19: Receive only from standby
// R20: Host calibrates first and periodically
// R21: Calibration only in standby on channel 19
// R22: Power register zero returns to standby
// R23: Value 0x3F enters battery protection
// R24: Flags mark power-saving exit to standby
// R25: Non-standby mode requests are ignored
`timescale 1ns/100ps
module romc_ctrl
#(
	parameter bit HAS_CONVERTER = 1'b1, // Converter-equipped variant
	parameter int STANDBY_RF_CYC = romc_pkg::T_STDBY_RF_CYC, // Standby to radio settle
	parameter int RX_TX_CYC = romc_pkg::T_RX_TX_CYC, // Turnaround settle
	parameter int AUTOCAL_CYC = romc_pkg::T_AUTOCAL_CYC, // Calibration run
	parameter int LP_EXIT_CYC = romc_pkg::T_LPSTDBY_EXIT_CYC, // Low-power exit
	parameter int DEEP_EXIT_CYC = romc_pkg::T_DEEP_EXIT_CYC // Deep idle exit
)
(
	input wire logic i_clock, // 40 MHz clock
	input wire logic i_reset_n, // Synchronous reset, active low
	input wire logic i_rc_running, // RC oscillator started
	input wire logic i_supply_ok, // supply_level_detector adequate
	input wire logic i_xtal_ready, // Crystal amplitude sufficient
	input wire logic i_cmd_valid, // Host command strobe
	input wire romc_pkg::romc_cmd_t i_cmd, // Host command
	input wire logic [7:0] i_power_mode_register, // Written power_mode_register value
	input wire logic [5:0] i_channel, // Current radio channel
	input wire logic i_auto_ack, // Auto-acknowledge enabled
	input wire logic [3:0] i_burst_count, // Extra packets after first
	input wire logic [3:0] i_retry_max, // Retransmission limit
	input wire logic i_irq_enable, // Radio interrupt enabled
	input wire logic i_status_clear, // Clear sticky exit flags
	input wire logic i_packet_sent, // Modulator finished packet
	input wire logic i_packet_received, // Good packet received
	input wire logic i_ack_ok, // Good ack received
	input wire logic i_ack_error, // Ack reported error
	input wire logic i_ack_timeout, // Ack window expired
	output logic o_irq, // Interrupt pin
	output logic o_radio_enable, // Radio transceiver powered
	output logic o_tx_on, // Transmitter active
	output logic o_rx_on, // Receiver active
	output logic o_cal_on, // Synthesizer calibration running
	output logic o_xtal_enable, // Crystal oscillator on
	output logic o_xtal_low_current, // Crystal at reduced current
	output logic o_rc_enable, // RC oscillator on
	output logic o_full_regulation, // Converter full regulation
	output logic o_core_supply_low, // Core supply lowered
	output logic o_sys_clk_slow, // System logic on 400 kHz enable
	output logic o_load_only, // Only resistive load on
	output logic o_standby_reached, // Sticky flag, power-save exit done
	output logic o_retry_exhausted, // Sticky flag, retries used up
	output romc_pkg::romc_mode_t o_mode // Current mode
);
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		romc_pkg::romc_mode_t mode;
		romc_pkg::romc_mode_t settle_to;
		romc_pkg::romc_mode_t exit_to;
		logic [3:0] burst_left;
		logic [3:0] retries;
		logic irq;
		logic xtal_en;
		logic rc_en;
		logic full_reg;
		logic booted;
		logic standby_reached;
		logic retry_exhausted;
	} romc_state_t;
	romc_state_t state, next_state;

	romc_timer_if tmr ();
	logic slow_en;
	logic pwr_cmd, bp_cmd, wake_cmd;
	logic [romc_pkg::TIMER_W-1:0] load_count;
	logic load;

	romc_timer u_timer (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_slow(state.mode == romc_pkg::ROMC_LP_STANDBY),
		.o_slow_en(slow_en),
		.t(tmr.timer)
	);
	assign tmr.load = load;
	assign tmr.count = load_count;

	assign pwr_cmd = i_cmd_valid && i_cmd == romc_pkg::ROMC_CMD_POWER;
	assign bp_cmd = pwr_cmd && i_power_mode_register[5:0] == romc_pkg::PWR_BATT_PROT; // R23
	assign wake_cmd = pwr_cmd && i_power_mode_register == romc_pkg::PWR_STANDBY; // R22

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		load = 1'b0;
		load_count = '0;
		case (state.mode)
			romc_pkg::ROMC_BOOT_RC:
			begin
				if (HAS_CONVERTER ? i_supply_ok : i_rc_running) // R2 R4
					next_state.xtal_en = 1'b1;
				if (state.xtal_en)
					next_state.mode = romc_pkg::ROMC_BOOT_XTAL;
			end
			romc_pkg::ROMC_BOOT_XTAL:
			begin
				if (i_xtal_ready)
				begin
					next_state.full_reg = HAS_CONVERTER; // R2
					next_state.rc_en = 1'b0; // R4
					next_state.irq = 1'b1; // R3
					next_state.booted = 1'b1;
					next_state.mode = romc_pkg::ROMC_STANDBY; // R5
				end
			end
			romc_pkg::ROMC_STANDBY:
			begin
				if (i_cmd_valid) // R6 R25
				begin
					next_state.irq = 1'b0;
					case (i_cmd)
						romc_pkg::ROMC_CMD_TX: // R17
						begin
							next_state.burst_left = i_burst_count;
							next_state.retries = 4'h0;
							next_state.settle_to = romc_pkg::ROMC_TX;
							next_state.mode = romc_pkg::ROMC_SETTLE;
							load = 1'b1;
							load_count = romc_pkg::TIMER_W'(STANDBY_RF_CYC);
						end
						romc_pkg::ROMC_CMD_RX: // R19
						begin
							next_state.settle_to = romc_pkg::ROMC_RX;
							next_state.mode = romc_pkg::ROMC_SETTLE;
							load = 1'b1;
							load_count = romc_pkg::TIMER_W'(STANDBY_RF_CYC);
						end
						romc_pkg::ROMC_CMD_CAL:
						begin
							if (i_channel == romc_pkg::CAL_CHANNEL) // R21
							begin
								next_state.mode = romc_pkg::ROMC_CAL;
								load = 1'b1;
								load_count = romc_pkg::TIMER_W'(AUTOCAL_CYC);
							end
						end
						romc_pkg::ROMC_CMD_POWER:
						begin
							if (i_power_mode_register[romc_pkg::PWR_DEEP_IDLE_BIT]) // R11
								next_state.mode = romc_pkg::ROMC_DEEP_IDLE;
							else if (i_power_mode_register[romc_pkg::PWR_LP_STANDBY_BIT]) // R13
								next_state.mode = romc_pkg::ROMC_LP_STANDBY;
						end
						default:
						begin
							next_state.irq = state.irq;
						end
					endcase
				end
			end
			romc_pkg::ROMC_SETTLE:
			begin
				if (tmr.done)
					next_state.mode = state.settle_to;
			end
			romc_pkg::ROMC_TX:
			begin
				if (i_packet_sent)
				begin
					if (i_auto_ack) // R15
					begin
						next_state.mode = romc_pkg::ROMC_SETTLE;
						next_state.settle_to = romc_pkg::ROMC_TX_ACK_WAIT;
						load = 1'b1;
						load_count = romc_pkg::TIMER_W'(RX_TX_CYC);
					end
					else if (state.burst_left != 4'h0) // R17
						next_state.burst_left = state.burst_left - 4'h1;
					else
					begin
						next_state.mode = romc_pkg::ROMC_STANDBY; // R7 R14
						next_state.irq = i_irq_enable;
					end
				end
			end
			romc_pkg::ROMC_TX_ACK_WAIT:
			begin
				if (i_ack_ok)
				begin
					next_state.retries = 4'h0;
					next_state.mode = romc_pkg::ROMC_SETTLE;
					load = 1'b1;
					load_count = romc_pkg::TIMER_W'(RX_TX_CYC);
					if (state.burst_left != 4'h0)
					begin
						next_state.burst_left = state.burst_left - 4'h1;
						next_state.settle_to = romc_pkg::ROMC_TX;
					end
					else
					begin
						next_state.mode = romc_pkg::ROMC_STANDBY; // R15
						next_state.irq = i_irq_enable;
						load = 1'b0;
					end
				end
				else if (i_ack_error || i_ack_timeout)
				begin
					// Retry limit bounds the loop; a dead link would otherwise burn the battery
					if (state.retries == i_retry_max)
					begin
						next_state.retry_exhausted = 1'b1;
						next_state.mode = romc_pkg::ROMC_STANDBY;
						next_state.irq = i_irq_enable;
					end
					else
					begin
						next_state.retries = state.retries + 4'h1; // R16
						next_state.settle_to = romc_pkg::ROMC_TX;
						next_state.mode = romc_pkg::ROMC_SETTLE;
						load = 1'b1;
						load_count = romc_pkg::TIMER_W'(RX_TX_CYC);
					end
				end
			end
			romc_pkg::ROMC_RX:
			begin
				if (i_packet_received)
				begin
					next_state.irq = i_irq_enable; // R18
					if (i_auto_ack)
					begin
						next_state.settle_to = romc_pkg::ROMC_RX_ACK_TX;
						next_state.mode = romc_pkg::ROMC_SETTLE;
						load = 1'b1;
						load_count = romc_pkg::TIMER_W'(RX_TX_CYC);
					end
				end
			end
			romc_pkg::ROMC_RX_ACK_TX:
			begin
				if (i_packet_sent) // R18
				begin
					next_state.settle_to = romc_pkg::ROMC_RX;
					next_state.mode = romc_pkg::ROMC_SETTLE;
					load = 1'b1;
					load_count = romc_pkg::TIMER_W'(RX_TX_CYC);
				end
			end
			romc_pkg::ROMC_CAL:
			begin
				if (tmr.done)
				begin
					next_state.mode = romc_pkg::ROMC_STANDBY;
					next_state.irq = i_irq_enable;
				end
			end
			romc_pkg::ROMC_DEEP_IDLE, romc_pkg::ROMC_LP_STANDBY:
			begin
				if (wake_cmd) // R22
				begin
					next_state.mode = romc_pkg::ROMC_EXIT_WAIT;
					load = 1'b1;
					// Low-power standby keeps the crystal alive, so it wakes sooner
					load_count = (state.mode == romc_pkg::ROMC_LP_STANDBY) ?
						romc_pkg::TIMER_W'(LP_EXIT_CYC) : romc_pkg::TIMER_W'(DEEP_EXIT_CYC); // R13
				end
			end
			romc_pkg::ROMC_EXIT_WAIT:
			begin
				if (tmr.done)
				begin
					next_state.mode = romc_pkg::ROMC_STANDBY;
					next_state.standby_reached = 1'b1; // R24
					next_state.irq = i_irq_enable; // R24
				end
			end
			romc_pkg::ROMC_BATT_PROT:
			begin
				next_state.irq = 1'b0; // R8
			end
			default:
			begin
				next_state.mode = romc_pkg::ROMC_STANDBY;
			end
		endcase
		// Clear loses to a same-cycle set
		if (i_status_clear)
		begin
			if (!(state.mode == romc_pkg::ROMC_EXIT_WAIT && tmr.done))
				next_state.standby_reached = 1'b0;
			if (!(state.mode == romc_pkg::ROMC_TX_ACK_WAIT && !i_ack_ok && (i_ack_error || i_ack_timeout)
				&& state.retries == i_retry_max))
				next_state.retry_exhausted = 1'b0;
		end
		if (bp_cmd && state.booted) // R9
		begin
			next_state.mode = romc_pkg::ROMC_BATT_PROT; // R8
			next_state.irq = 1'b0;
			load = 1'b0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			state <= '0;
			state.rc_en <= 1'b1;
			state.mode <= romc_pkg::ROMC_BOOT_RC;
			state.settle_to <= romc_pkg::ROMC_STANDBY;
			state.exit_to <= romc_pkg::ROMC_STANDBY;
		end
		else if (state.mode != romc_pkg::ROMC_BATT_PROT) // R8
			state <= next_state;
	end

	// -----------------------------------------------------------------
	// Outputs, all registered
	// -----------------------------------------------------------------
	typedef struct packed {
		logic irq, radio, tx, rx, cal, xtal, xlow, rc, reg_full;
		logic core_low, slow, load_only, sreached, rexh;
		romc_pkg::romc_mode_t mode;
	} romc_out_t;
	romc_out_t out, next_out;

	always_comb
	begin
		next_out.irq = next_state.irq;
		next_out.radio = next_state.booted && next_state.mode inside
			{romc_pkg::ROMC_TX, romc_pkg::ROMC_TX_ACK_WAIT, romc_pkg::ROMC_RX,
			romc_pkg::ROMC_RX_ACK_TX, romc_pkg::ROMC_CAL, romc_pkg::ROMC_SETTLE}; // R1
		next_out.tx = next_state.mode inside {romc_pkg::ROMC_TX, romc_pkg::ROMC_RX_ACK_TX};
		next_out.rx = next_state.mode inside {romc_pkg::ROMC_RX, romc_pkg::ROMC_TX_ACK_WAIT};
		next_out.cal = next_state.mode == romc_pkg::ROMC_CAL;
		next_out.xtal = next_state.xtal_en && next_state.mode != romc_pkg::ROMC_DEEP_IDLE
			&& next_state.mode != romc_pkg::ROMC_BATT_PROT;
		next_out.xlow = next_state.mode == romc_pkg::ROMC_LP_STANDBY; // R12
		next_out.rc = next_state.rc_en && next_state.mode != romc_pkg::ROMC_BATT_PROT;
		next_out.reg_full = next_state.full_reg && next_state.mode != romc_pkg::ROMC_BATT_PROT;
		next_out.core_low = next_state.mode == romc_pkg::ROMC_DEEP_IDLE; // R11
		next_out.slow = next_state.mode == romc_pkg::ROMC_LP_STANDBY; // R12
		next_out.load_only = next_state.mode == romc_pkg::ROMC_BATT_PROT; // R8
		next_out.sreached = next_state.standby_reached;
		next_out.rexh = next_state.retry_exhausted;
		next_out.mode = next_state.mode;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			out <= '0;
			out.rc <= 1'b1;
			out.mode <= romc_pkg::ROMC_BOOT_RC;
		end
		else if (state.mode != romc_pkg::ROMC_BATT_PROT)
			out <= next_out;
	end

	assign o_irq = out.irq;
	assign o_radio_enable = out.radio;
	assign o_tx_on = out.tx;
	assign o_rx_on = out.rx;
	assign o_cal_on = out.cal;
	assign o_xtal_enable = out.xtal;
	assign o_xtal_low_current = out.xlow;
	assign o_rc_enable = out.rc;
	assign o_full_regulation = out.reg_full;
	assign o_core_supply_low = out.core_low;
	assign o_sys_clk_slow = out.slow;
	assign o_load_only = out.load_only;
	assign o_standby_reached = out.sreached;
	assign o_retry_exhausted = out.rexh;
	assign o_mode = out.mode;
endmodule // romc_ctrl

// File: testbench/romc_ctrl_props.sv
/*
 Port-level assertions for the operating mode controller.
 Assumes it is bound to romc_ctrl and shares its single clock domain.
*/
`timescale 1ns/100ps
module romc_ctrl_props
#(
	parameter bit HAS_CONVERTER = 1'b1 // Converter variant
)
(
	input wire logic i_clock, // Clock
	input wire logic i_reset_n, // Reset
	input wire logic i_supply_ok, // Supply ok
	input wire logic i_cmd_valid, // Strobe
	input wire romc_pkg::romc_cmd_t i_cmd, // Command
	input wire logic [7:0] i_power_mode_register, // Power value
	input wire logic [5:0] i_channel, // Channel
	input wire logic i_auto_ack, // Auto-ack
	input wire logic [3:0] i_burst_count, // Burst
	input wire logic i_packet_sent, // Sent
	input wire logic o_irq, // Interrupt
	input wire logic o_radio_enable, // Radio on
	input wire logic o_tx_on, // Tx on
	input wire logic o_rx_on, // Rx on
	input wire logic o_xtal_enable, // Crystal on
	input wire logic o_xtal_low_current, // Weak crystal
	input wire logic o_full_regulation, // Regulation
	input wire logic o_core_supply_low, // Low core
	input wire logic o_sys_clk_slow, // Slow clock
	input wire logic o_load_only, // Load only
	input wire logic o_standby_reached, // Exit flag
	input wire romc_pkg::romc_mode_t o_mode // Mode
);
	logic boot, in_sb, pwr_cmd;
	assign boot = o_mode == romc_pkg::ROMC_BOOT_RC || o_mode == romc_pkg::ROMC_BOOT_XTAL;
	assign in_sb = o_mode == romc_pkg::ROMC_STANDBY;
	assign pwr_cmd = i_cmd_valid && i_cmd == romc_pkg::ROMC_CMD_POWER;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);

	a_boot_radio_off: assert property (boot |-> !(o_radio_enable || o_tx_on || o_rx_on))
		else $error("radio on in boot");
	a_xtal_on_supply: assert property (HAS_CONVERTER && boot && i_supply_ok |-> ##[1:3] o_xtal_enable)
		else $error("no crystal");
	a_ready_irq: assert property ($past(o_mode) == romc_pkg::ROMC_BOOT_XTAL && in_sb |-> o_irq && o_full_regulation)
		else $error("no ready irq");
	a_deep_from_sb: assert property (o_mode == romc_pkg::ROMC_DEEP_IDLE && $past(o_mode) != romc_pkg::ROMC_DEEP_IDLE
		|-> $past(o_mode) == romc_pkg::ROMC_STANDBY)
		else $error("bad deep entry");
	a_deep_supply: assert property (o_mode == romc_pkg::ROMC_DEEP_IDLE |-> o_core_supply_low)
		else $error("core not low");
	a_lp_clock: assert property (o_mode == romc_pkg::ROMC_LP_STANDBY |-> o_sys_clk_slow && o_xtal_low_current && o_xtal_enable)
		else $error("bad lp clock");
	a_lp_from_sb: assert property (o_mode == romc_pkg::ROMC_LP_STANDBY && $past(o_mode) != romc_pkg::ROMC_LP_STANDBY
		|-> $past(o_mode) == romc_pkg::ROMC_STANDBY)
		else $error("bad lp entry");
	a_batt_hold: assert property (o_mode == romc_pkg::ROMC_BATT_PROT |=> o_mode == romc_pkg::ROMC_BATT_PROT && o_load_only)
		else $error("left protection");
	a_batt_entry: assert property (pwr_cmd && i_power_mode_register[5:0] == romc_pkg::PWR_BATT_PROT && !boot
		|-> ##2 o_mode == romc_pkg::ROMC_BATT_PROT)
		else $error("protection missed");
	a_tx_done: assert property (o_mode == romc_pkg::ROMC_TX && i_packet_sent && !i_auto_ack && i_burst_count == 4'h0
		|-> ##[1:3] in_sb)
		else $error("no tx return");
	a_ack_wait: assert property (o_mode == romc_pkg::ROMC_TX && i_packet_sent && i_auto_ack
		|-> ##[1:30] o_mode == romc_pkg::ROMC_TX_ACK_WAIT && o_rx_on)
		else $error("no ack wait");
	a_wake: assert property ((o_mode == romc_pkg::ROMC_DEEP_IDLE || o_mode == romc_pkg::ROMC_LP_STANDBY) && pwr_cmd
		&& i_power_mode_register == romc_pkg::PWR_STANDBY |-> ##[2:200] in_sb && o_standby_reached)
		else $error("wake failed");
	a_cal_channel: assert property (in_sb && i_cmd_valid && i_cmd == romc_pkg::ROMC_CMD_CAL && i_channel != romc_pkg::CAL_CHANNEL
		|-> ##2 in_sb)
		else $error("cal off channel");
endmodule // romc_ctrl_props

bind romc_ctrl romc_ctrl_props #(.HAS_CONVERTER(HAS_CONVERTER)) i_props (.*);

// File: testbench/romc_host_model.sv
/*
 Host controller model: issues decoded one-cycle mode commands.
 Assumes the caller waits for standby unless it means to be refused.
*/
`timescale 1ns/100ps
module romc_host_model
(
	input wire logic i_clock, // Clock
	output logic o_cmd_valid, // Strobe
	output romc_pkg::romc_cmd_t o_cmd, // Command
	output logic [7:0] o_power // Power value
);
	initial
	begin
		o_cmd_valid = 1'b0;
		o_cmd = romc_pkg::ROMC_CMD_NONE;
		o_power = 8'h00;
	end

	// Released value flips so a stale register is never mistaken for a command
	task automatic send(input romc_pkg::romc_cmd_t c, input logic [7:0] v);
		@(posedge i_clock);
		#1;
		o_cmd_valid = 1'b1;
		o_cmd = c;
		o_power = v;
		@(posedge i_clock);
		#1;
		o_cmd_valid = 1'b0;
		o_cmd = romc_pkg::ROMC_CMD_NONE;
		o_power = ~v;
	endtask
endmodule // romc_host_model

// File: testbench/romc_ctrl_test.sv
/*
 Self-checking bench of the operating mode controller.
 Assumes shortened settling counts; radio events are bench pulses.
*/
`timescale 1ns/100ps
module romc_ctrl_test;
	logic i_clock, rst_n, supply_ok, xtal_ready, auto_ack, irq_en, clr, cmd_valid;
	logic [5:0] channel;
	logic [3:0] burst, rmax;
	logic [4:0] ev;
	logic [7:0] power;
	romc_pkg::romc_cmd_t cmd;
	romc_pkg::romc_mode_t o_mode;
	logic o_irq, o_radio_enable, o_tx_on, o_rx_on, o_cal_on, o_xtal_enable, o_xtal_low_current;
	logic o_full_regulation, o_core_supply_low, o_sys_clk_slow, o_load_only, o_standby_reached;
	int errors, n_checks, t, t_deep, t_lp;

	romc_host_model i_host (.i_clock(i_clock), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_power(power));
	romc_ctrl #(.STANDBY_RF_CYC(8), .RX_TX_CYC(6), .AUTOCAL_CYC(12), .LP_EXIT_CYC(6), .DEEP_EXIT_CYC(20)) i_dut (
		.i_clock(i_clock), .i_reset_n(rst_n), .i_rc_running(supply_ok), .i_supply_ok(supply_ok), .i_xtal_ready(xtal_ready),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_power_mode_register(power), .i_channel(channel),
		.i_auto_ack(auto_ack), .i_burst_count(burst), .i_retry_max(rmax), .i_irq_enable(irq_en), .i_status_clear(clr),
		.i_packet_sent(ev[0]), .i_packet_received(ev[1]), .i_ack_ok(ev[2]), .i_ack_error(ev[3]),
		.i_ack_timeout(ev[4]), .o_irq(o_irq), .o_radio_enable(o_radio_enable), .o_tx_on(o_tx_on), .o_rx_on(o_rx_on),
		.o_cal_on(o_cal_on), .o_xtal_enable(o_xtal_enable), .o_xtal_low_current(o_xtal_low_current), .o_rc_enable(),
		.o_full_regulation(o_full_regulation), .o_core_supply_low(o_core_supply_low), .o_sys_clk_slow(o_sys_clk_slow),
		.o_load_only(o_load_only), .o_standby_reached(o_standby_reached), .o_retry_exhausted(), .o_mode(o_mode));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic wait_mode(input romc_pkg::romc_mode_t m, input int lim, output int k);
		k = 0;
		while (o_mode !== m && k < lim)
		begin
			@(posedge i_clock);
			#1;
			k++;
		end
		chk({4'h0, o_mode}, {4'h0, m}, "mode");
	endtask

	task automatic pulse(input logic [4:0] v);
		@(posedge i_clock);
		#1;
		ev = v;
		@(posedge i_clock);
		#1;
		ev = 5'h00;
	endtask

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (16) @(posedge i_clock);
		#1;
		rst_n = 1'b1;
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_boot;
		chk({7'h0, o_radio_enable}, 8'h00, "radio in boot");
		supply_ok = 1'b1;
		wait_mode(romc_pkg::ROMC_BOOT_XTAL, 10, t);
		chk({7'h0, o_full_regulation}, 8'h00, "early regulation");
		xtal_ready = 1'b1;
		wait_mode(romc_pkg::ROMC_STANDBY, 10, t);
		chk({6'h0, o_irq, o_full_regulation}, 8'h03, "ready");
		$display("boot done");
	endtask

	task automatic t_cal;
		channel = 6'h05;
		i_host.send(romc_pkg::ROMC_CMD_CAL, 8'h00);
		repeat (4) @(posedge i_clock);
		chk({4'h0, o_mode}, {4'h0, romc_pkg::ROMC_STANDBY}, "cal off channel");
		channel = romc_pkg::CAL_CHANNEL;
		i_host.send(romc_pkg::ROMC_CMD_CAL, 8'h00);
		wait_mode(romc_pkg::ROMC_CAL, 10, t);
		chk({7'h0, o_cal_on}, 8'h01, "cal on");
		wait_mode(romc_pkg::ROMC_STANDBY, 40, t);
		$display("calibration done");
	endtask

	task automatic t_tx;
		burst = 4'h1;
		i_host.send(romc_pkg::ROMC_CMD_TX, 8'h00);
		wait_mode(romc_pkg::ROMC_TX, 40, t);
		chk({7'h0, o_tx_on}, 8'h01, "tx on");
		i_host.send(romc_pkg::ROMC_CMD_RX, 8'h00);
		repeat (4) @(posedge i_clock);
		chk({4'h0, o_mode}, {4'h0, romc_pkg::ROMC_TX}, "rx in tx");
		pulse(5'h01);
		burst = 4'h0;
		chk({4'h0, o_mode}, {4'h0, romc_pkg::ROMC_TX}, "burst");
		pulse(5'h01);
		wait_mode(romc_pkg::ROMC_STANDBY, 5, t);
		chk({7'h0, o_irq}, 8'h01, "tx irq");
		$display("transmit done");
	endtask

	task automatic t_ack;
		auto_ack = 1'b1;
		i_host.send(romc_pkg::ROMC_CMD_TX, 8'h00);
		for (int i = 4; i > 1; i--)
		begin
			wait_mode(romc_pkg::ROMC_TX, 60, t);
			pulse(5'h01);
			wait_mode(romc_pkg::ROMC_TX_ACK_WAIT, 40, t);
			pulse(5'h01 << i);
		end
		wait_mode(romc_pkg::ROMC_STANDBY, 10, t);
		chk({7'h0, o_irq}, 8'h01, "ack irq");
		auto_ack = 1'b0;
		$display("auto-acknowledge done");
	endtask

	task automatic t_power;
		i_host.send(romc_pkg::ROMC_CMD_POWER, 8'h40);
		wait_mode(romc_pkg::ROMC_DEEP_IDLE, 5, t);
		chk({7'h0, o_core_supply_low}, 8'h01, "core low");
		i_host.send(romc_pkg::ROMC_CMD_TX, 8'h00);
		repeat (4) @(posedge i_clock);
		chk({4'h0, o_mode}, {4'h0, romc_pkg::ROMC_DEEP_IDLE}, "tx in deep");
		i_host.send(romc_pkg::ROMC_CMD_POWER, romc_pkg::PWR_STANDBY);
		wait_mode(romc_pkg::ROMC_STANDBY, 100, t_deep);
		chk({7'h0, o_standby_reached}, 8'h01, "reached");
		@(posedge i_clock);
		#1;
		clr = 1'b1;
		@(posedge i_clock);
		#1;
		clr = 1'b0;
		#1;
		chk({7'h0, o_standby_reached}, 8'h00, "cleared");
		i_host.send(romc_pkg::ROMC_CMD_POWER, 8'h80);
		wait_mode(romc_pkg::ROMC_LP_STANDBY, 5, t);
		chk({6'h0, o_sys_clk_slow, o_xtal_low_current}, 8'h03, "lp clock");
		i_host.send(romc_pkg::ROMC_CMD_POWER, romc_pkg::PWR_STANDBY);
		wait_mode(romc_pkg::ROMC_STANDBY, 100, t_lp);
		chk({7'h0, t_lp < t_deep}, 8'h01, "lp faster");
		$display("power modes done");
	endtask

	task automatic t_rx;
		i_host.send(romc_pkg::ROMC_CMD_RX, 8'h00);
		wait_mode(romc_pkg::ROMC_RX, 40, t);
		pulse(5'h02);
		repeat (3) @(posedge i_clock);
		chk({3'h0, o_irq, o_mode}, {4'h1, romc_pkg::ROMC_RX}, "rx stay");
		auto_ack = 1'b1;
		pulse(5'h02);
		wait_mode(romc_pkg::ROMC_RX_ACK_TX, 30, t);
		chk({7'h0, o_tx_on}, 8'h01, "ack tx");
		pulse(5'h01);
		wait_mode(romc_pkg::ROMC_RX, 40, t);
		i_host.send(romc_pkg::ROMC_CMD_POWER, 8'h3f);
		wait_mode(romc_pkg::ROMC_BATT_PROT, 4, t);
		chk({6'h0, o_load_only, o_radio_enable}, 8'h02, "load only");
		i_host.send(romc_pkg::ROMC_CMD_POWER, romc_pkg::PWR_STANDBY);
		repeat (8) @(posedge i_clock);
		chk({4'h0, o_mode}, {4'h0, romc_pkg::ROMC_BATT_PROT}, "stuck");
		$display("receive and protection done");
	endtask

	initial
	begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	initial
	begin
		#1000000;
		errors++;
		conclude;
	end

	initial
	begin
		{supply_ok, xtal_ready, auto_ack, clr, ev, burst, errors, n_checks} = '0;
		irq_en = 1'b1;
		rmax = 4'h3;
		channel = 6'h00;
		do_reset;
		t_boot;
		t_cal;
		t_tx;
		t_ack;
		t_power;
		t_rx;
		do_reset;
		chk({4'h0, o_mode}, {4'h0, romc_pkg::ROMC_BOOT_RC}, "second reset");
		conclude;
	end
endmodule // romc_ctrl_test
